// ===== rtl/smlg_pkg.sv
// shared constants and types of the monitoring log and status command block
package smlg_pkg;
  // subcommand codes
  localparam logic [7:0] SC_RDATTR = 8'hd0;
  localparam logic [7:0] SC_SAVE   = 8'hd3;
  localparam logic [7:0] SC_OFFIMM = 8'hd4;
  localparam logic [7:0] SC_RDLOG  = 8'hd5;
  localparam logic [7:0] SC_WRLOG  = 8'hd6;
  localparam logic [7:0] SC_EN     = 8'hd8;
  localparam logic [7:0] SC_DIS    = 8'hd9;
  localparam logic [7:0] SC_STAT   = 8'hda;
  localparam logic [7:0] SC_AUTO   = 8'hdb;
  // automatic off-line control codes
  localparam logic [7:0] AO_AUTO_OFF = 8'h00;
  localparam logic [7:0] AO_SCAN_OFF = 8'h01;
  localparam logic [7:0] AO_AUTO_ON  = 8'hf8;
  localparam logic [7:0] AO_SCAN_ON  = 8'hf9;
  localparam logic [7:0] OFF_COLLECT = 8'h00;
  // status signatures
  localparam logic [7:0] SIG_OK_MID  = 8'h4f;
  localparam logic [7:0] SIG_OK_HIGH = 8'hc2;
  localparam logic [7:0] SIG_BAD_MID  = 8'hf4;
  localparam logic [7:0] SIG_BAD_HIGH = 8'h2c;
  // log addresses
  localparam logic [7:0] LA_DIR   = 8'h00;
  localparam logic [7:0] LA_ERR   = 8'h01;
  localparam logic [7:0] LA_CERR  = 8'h02;
  localparam logic [7:0] LA_STEST = 8'h06;
  localparam logic [7:0] LA_SEL   = 8'h09;
  localparam logic [7:0] LA_HOST0 = 8'h80;
  localparam logic [7:0] LA_HOST1 = 8'h9f;
  localparam int         LOG_SECTORS = 37;
  // attribute data structure layout
  localparam logic [9:0] SECTOR_BYTES = 10'h200;
  localparam logic [8:0] OFS_REV      = 9'h000;
  localparam logic [15:0] REV_VAL     = 16'h0010;
  localparam logic [8:0] OFS_ATTR     = 9'h002;
  localparam logic [8:0] ATTR_LEN     = 9'h00c;
  localparam int         N_ATTR       = 30;
  localparam logic [8:0] OFS_COLL     = 9'h16a;
  localparam logic [8:0] OFS_STEST    = 9'h16b;
  localparam logic [8:0] OFS_OCAP     = 9'h16f;
  localparam logic [7:0] OCAP_VAL     = 8'h5b;
  localparam logic [8:0] OFS_SCAP     = 9'h170;
  localparam logic [7:0] SCAP_VAL     = 8'h03;
  localparam logic [8:0] OFS_ELOG     = 9'h172;
  localparam logic [7:0] ELOG_VAL     = 8'h01;
  localparam logic [8:0] OFS_CSUM     = 9'h1ff;
  localparam logic [7:0] ATTR_INIT    = 8'h64;
  localparam int         SYNC_WAIT    = 2;
  typedef struct packed {
    logic [7:0] sub;
    logic [7:0] count;
    logic [7:0] addr;
  } smlg_cmd_type;
  typedef struct packed {
    logic [4:0] idx;
    logic [7:0] value;
    logic [7:0] thr;
    logic       prefail;
  } smlg_upd_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RD   = 3'b010,
    ST_WR   = 3'b100
  } smlg_state_type;
endpackage

// ===== rtl/smlg_top.sv
// monitoring log and status command block with its write-data fifo
// How it works
// - log read streams one 512-byte sector
// - fixed map of read-only and writable logs
// - log write stores one 512-byte block
// - write to read-only log aborts
// - no tracking until enable received
// - enable state kept for power cycles
// - repeated enable leaves attribute values alone
// - disable stops tracking and automatic off-line runs
// - while disabled abort all but enable
// - saved values kept, refreshed on read/save
// - status saves values then checks thresholds
// - no prefail crossing returns 4f/c2
// - prefail crossing returns f4/2c
// - off-line control code sets auto or scan
// - scan off skips read scan in collection
// - scan on scans even without auto
// - other nonzero code changes nothing, aborts
// - power-mode saves continue regardless
// - 512-byte structure, little-endian fields
// - revision 0010h then thirty attribute entries
// - status bytes, capability 5bh, checksum last
`timescale 1ns/1ps
module smlg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  // filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // draining side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rp_q];
  // ready is registered so the top sees it straight from a flop
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) cnt_d = cnt_q + 1'b1;
    if (pop && !push) cnt_d = cnt_q - 1'b1;
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wp_q     <= '0;
      rp_q     <= '0;
      cnt_q    <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q    <= cnt_d;
      in_ready <= (cnt_d != (AW+1)'(DEPTH));
    end
  end
  // storage, no reset needed
  always_ff @(posedge clock) begin
    if (push) mem[wp_q] <= in_data;
  end
endmodule

module smlg_top
  import smlg_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input  wire logic   clock,
  input  wire logic   nrst,
  // command from task file
  input  wire logic   cmd_valid,
  input  smlg_cmd_type cmd,
  output logic        busy,
  output logic        done,
  output logic        abort,
  output logic [7:0]  lba_mid,
  output logic [7:0]  lba_high,
  // data from host
  input  wire logic   din_valid,
  input  wire logic [7:0] din_data,
  output logic        din_ready,
  // data to host
  output logic        dout_valid,
  output logic [7:0]  dout_data,
  input  wire logic   dout_ready,
  // non-volatile enable state
  input  wire logic   nv_enable,
  output logic        enable_state,
  // attribute sampling and device events
  input  wire logic   upd_valid,
  input  smlg_upd_type upd,
  input  wire logic   power_save,
  input  wire logic   auto_tick,
  input  wire logic [7:0] coll_status,
  input  wire logic [7:0] stest_status,
  // off-line collection control
  output logic        offline_start,
  output logic        offline_scan,
  output logic        auto_offline,
  output logic        read_scan
);
  if (FIFO_DEPTH < 2) begin : g_chk
    $error("fifo depth too small");
  end
  // maps a log address to {valid, read_only, sector index}
  function automatic logic [7:0] log_map(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      LA_DIR:   r = 8'hc0;
      LA_ERR:   r = 8'hc1;
      LA_CERR:  r = 8'hc2;
      LA_STEST: r = 8'hc3;
      LA_SEL:   r = 8'h84;
      default: begin
        if (a >= LA_HOST0 && a <= LA_HOST1) r = {2'b10, 6'(a - LA_HOST0 + 8'h05)};
      end
    endcase
    return r;
  endfunction

  smlg_state_type state_q;
  logic [7:0]  log_mem [LOG_SECTORS*512];
  logic [7:0]  live_q [N_ATTR];
  logic [7:0]  thr_q [N_ATTR];
  logic        pf_q [N_ATTR];
  logic [7:0]  saved_q [N_ATTR];
  logic        nv_s1_q;
  logic        nv_s2_q;
  logic [1:0]  boot_q;
  logic        en_q;
  logic [7:0]  sub_q;
  logic [5:0]  idx_q;
  logic        attr_q;
  logic [9:0]  cnt_q;
  logic [7:0]  sum_q;
  logic        take;
  logic        bad;
  logic        ok;
  logic        fail;
  logic [7:0]  lm;
  logic [7:0]  rd_byte;
  logic [7:0]  st_byte;
  logic        fo_valid;
  logic [7:0]  fo_data;
  logic        fo_ready;
  logic        pop;

  // write data waits in the fifo; host stalls on din_ready
  smlg_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .nrst      (nrst),
    .in_valid  (din_valid),
    .in_data   (din_data),
    .in_ready  (din_ready),
    .out_valid (fo_valid),
    .out_data  (fo_data),
    .out_ready (fo_ready)
  );
  assign fo_ready = (state_q == ST_WR);
  assign pop      = fo_valid && fo_ready;
  assign take     = cmd_valid && !busy;
  assign ok       = !bad;
  assign lm       = log_map(cmd.addr);

  // command screening
  always_comb begin
    bad = 1'b0;
    if (!en_q && cmd.sub != SC_EN) begin
      bad = 1'b1;
    end else begin
      unique case (cmd.sub)
        SC_RDLOG: bad = (cmd.count != 8'h01) || !lm[7];
        SC_WRLOG: bad = (cmd.count != 8'h01) || !lm[7] || lm[6];
        SC_AUTO: begin
          bad = !(cmd.count == AO_AUTO_OFF || cmd.count == AO_SCAN_OFF ||
                  cmd.count == AO_AUTO_ON || cmd.count == AO_SCAN_ON);
        end
        SC_OFFIMM: bad = (cmd.addr != OFF_COLLECT); // self-tests live elsewhere
        SC_RDATTR, SC_SAVE, SC_EN, SC_DIS, SC_STAT: bad = 1'b0;
        default: bad = 1'b1;
      endcase
    end
  end

  // threshold check over live values, same as values just saved
  always_comb begin
    fail = 1'b0;
    for (int i = 0; i < N_ATTR; i++) begin
      if (pf_q[i] && thr_q[i] != 8'h00 && live_q[i] <= thr_q[i]) fail = 1'b1;
    end
  end

  // attribute structure byte at the current count
  always_comb begin
    logic [8:0] a;
    logic [8:0] k;
    logic [4:0] e;
    a = cnt_q[8:0];
    k = 9'h000;
    e = 5'h00;
    st_byte = 8'h00; // reserved and vendor bytes stay zero
    if (a == OFS_REV) st_byte = REV_VAL[7:0];
    else if (a == OFS_REV + 9'h001) st_byte = REV_VAL[15:8];
    else if (a >= OFS_ATTR && a < OFS_COLL) begin
      e = 5'((a - OFS_ATTR) / ATTR_LEN);
      k = (a - OFS_ATTR) % ATTR_LEN;
      if (k == 9'h000) st_byte = 8'(e + 5'h01);
      else if (k == 9'h001) st_byte = {6'h00, 1'b1, pf_q[e]};
      else if (k == 9'h003) st_byte = saved_q[e];
    end
    else if (a == OFS_COLL) st_byte = coll_status;
    else if (a == OFS_STEST) st_byte = stest_status;
    else if (a == OFS_OCAP) st_byte = OCAP_VAL;
    else if (a == OFS_SCAP) st_byte = SCAP_VAL;
    else if (a == OFS_ELOG) st_byte = ELOG_VAL;
    else if (a == OFS_CSUM) st_byte = 8'h00 - sum_q;
  end
  assign rd_byte = attr_q ? st_byte : log_mem[{idx_q, cnt_q[8:0]}];

  // pin synchroniser and boot load of the kept enable state
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      nv_s1_q <= 1'b0;
      nv_s2_q <= 1'b0;
      boot_q  <= 2'd0;
    end else begin
      nv_s1_q <= nv_enable;
      nv_s2_q <= nv_s1_q;
      if (boot_q != 2'(SYNC_WAIT + 1)) boot_q <= boot_q + 2'd1;
    end
  end

  // global enable, kept outside through enable_state
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      en_q <= 1'b0;
    end else if (boot_q == 2'(SYNC_WAIT)) begin
      en_q <= nv_s2_q;
    end else if (take && ok && cmd.sub == SC_EN) begin
      en_q <= 1'b1;
    end else if (take && ok && cmd.sub == SC_DIS) begin
      en_q <= 1'b0;
    end
  end
  assign enable_state = en_q;

  // off-line settings and start pulse
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      auto_offline  <= 1'b0;
      read_scan     <= 1'b0;
      offline_start <= 1'b0;
      offline_scan  <= 1'b0;
    end else begin
      if (take && ok && cmd.sub == SC_AUTO) begin
        if (cmd.count == AO_AUTO_OFF) auto_offline <= 1'b0;
        if (cmd.count == AO_AUTO_ON) auto_offline <= 1'b1;
        if (cmd.count == AO_SCAN_OFF) read_scan <= 1'b0;
        if (cmd.count == AO_SCAN_ON) read_scan <= 1'b1;
      end
      // auto runs need both global and auto enable
      offline_start <= (take && ok && cmd.sub == SC_OFFIMM) ||
                       (auto_tick && en_q && auto_offline);
      offline_scan  <= read_scan;
    end
  end

  // attribute tracking and saving
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < N_ATTR; i++) begin
        live_q[i]  <= ATTR_INIT;
        thr_q[i]   <= 8'h00;
        pf_q[i]    <= 1'b0;
        saved_q[i] <= ATTR_INIT;
      end
    end else begin
      if (upd_valid && en_q && upd.idx < 5'(N_ATTR)) begin
        live_q[upd.idx] <= upd.value;
        thr_q[upd.idx]  <= upd.thr;
        pf_q[upd.idx]   <= upd.prefail;
      end
      // power-mode saves ignore the enable state
      if (power_save || (take && ok && (cmd.sub == SC_SAVE ||
          cmd.sub == SC_RDATTR || cmd.sub == SC_STAT))) begin
        for (int i = 0; i < N_ATTR; i++) saved_q[i] <= live_q[i];
      end
    end
  end

  // command sequencer and task-file answer
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q    <= ST_IDLE;
      busy       <= 1'b1;
      done       <= 1'b0;
      abort      <= 1'b0;
      lba_mid    <= 8'h00;
      lba_high   <= 8'h00;
      sub_q      <= 8'h00;
      idx_q      <= 6'h00;
      attr_q     <= 1'b0;
      cnt_q      <= 10'h000;
      sum_q      <= 8'h00;
      dout_valid <= 1'b0;
      dout_data  <= 8'h00;
    end else begin
      done <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (boot_q == 2'(SYNC_WAIT + 1) && !take) busy <= 1'b0;
          if (take) begin
            sub_q  <= cmd.sub;
            idx_q  <= lm[5:0];
            attr_q <= (cmd.sub == SC_RDATTR);
            cnt_q  <= 10'h000;
            sum_q  <= 8'h00;
            abort  <= bad;
            if (ok && (cmd.sub == SC_RDLOG || cmd.sub == SC_RDATTR)) begin
              state_q <= ST_RD;
            end else if (ok && cmd.sub == SC_WRLOG) begin
              state_q <= ST_WR;
            end else begin
              done <= 1'b1;
              busy <= 1'b0;
            end
            if (ok && cmd.sub == SC_STAT) begin
              lba_mid  <= fail ? SIG_BAD_MID : SIG_OK_MID;
              lba_high <= fail ? SIG_BAD_HIGH : SIG_OK_HIGH;
            end
            if (bad) busy <= 1'b0;
            else busy <= 1'b1;
          end
        end
        ST_RD: begin
          if (!dout_valid || dout_ready) begin
            if (cnt_q == SECTOR_BYTES) begin
              dout_valid <= 1'b0;
              state_q    <= ST_IDLE;
              done       <= 1'b1;
              busy       <= 1'b0;
            end else begin
              dout_valid <= 1'b1;
              dout_data  <= rd_byte;
              sum_q      <= sum_q + rd_byte;
              cnt_q      <= cnt_q + 10'h001;
            end
          end
        end
        ST_WR: begin
          if (pop) begin
            cnt_q <= cnt_q + 10'h001;
            if (cnt_q == SECTOR_BYTES - 10'h001) begin
              state_q <= ST_IDLE;
              done    <= 1'b1;
              busy    <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // log sector storage
  always_ff @(posedge clock) begin
    if (pop) log_mem[{idx_q, cnt_q[8:0]}] <= fo_data;
  end

  property p_ro_abort;
    @(posedge clock) disable iff (!nrst)
    take && en_q && cmd.sub == SC_WRLOG && lm[6] |=> done && abort;
  endproperty
  a_ro_abort: assert property (p_ro_abort) else $error("read-only write not aborted");
  property p_dis_abort;
    @(posedge clock) disable iff (!nrst)
    take && !en_q && cmd.sub != SC_EN |=> done && abort && !en_q;
  endproperty
  a_dis_abort: assert property (p_dis_abort) else $error("disabled command ran");
  property p_enable;
    @(posedge clock) disable iff (!nrst)
    take && cmd.sub == SC_EN |=> en_q && done && !abort;
  endproperty
  a_enable: assert property (p_enable) else $error("enable not taken");
  property p_pass;
    @(posedge clock) disable iff (!nrst)
    take && ok && cmd.sub == SC_STAT && !fail |=> lba_mid == 8'h4f && lba_high == 8'hc2;
  endproperty
  a_pass: assert property (p_pass) else $error("wrong pass signature");
  property p_fail;
    @(posedge clock) disable iff (!nrst)
    take && ok && cmd.sub == SC_STAT && fail |=> lba_mid == 8'hf4 && lba_high == 8'h2c;
  endproperty
  a_fail: assert property (p_fail) else $error("wrong fail signature");
  property p_rd_len;
    @(posedge clock) disable iff (!nrst)
    done && !abort && (sub_q == SC_RDLOG || sub_q == SC_RDATTR) |-> cnt_q == 10'h200;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read length not 512");
  property p_wr_len;
    @(posedge clock) disable iff (!nrst)
    done && !abort && sub_q == SC_WRLOG |-> cnt_q == 10'h200 && $past(pop);
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write length not 512");
  property p_ao_bad;
    @(posedge clock) disable iff (!nrst)
    take && en_q && cmd.sub == SC_AUTO && bad |=>
      $stable(auto_offline) && $stable(read_scan) && abort;
  endproperty
  a_ao_bad: assert property (p_ao_bad) else $error("bad code changed settings");
  property p_scan;
    @(posedge clock) disable iff (!nrst)
    offline_start |-> offline_scan == $past(read_scan);
  endproperty
  a_scan: assert property (p_scan) else $error("scan flag not applied");
endmodule

// ===== bench/smlg_host_model.sv
// host-side sink for the read stream of the command block
`timescale 1ns/1ps
module smlg_host_model (
  // clock
  input  wire logic       clock,
  // read stream from the device
  input  wire logic       dout_valid,
  input  wire logic [7:0] dout_data,
  output logic            dout_ready,
  // capture control and result
  input  wire logic       cap_clear,
  output logic [9:0]      cap_count
);
  logic [7:0] cap_mem [0:511];
  logic [1:0] phase;

  // known start so the first sector is captured from offset zero
  initial begin
    dout_ready = 1'b0;
    phase = 2'h0;
    cap_count = 10'h000;
  end

  // ready drops one cycle in four so the device must hold its byte
  always @(negedge clock) begin
    phase <= phase + 2'h1;
    dout_ready <= (phase != 2'h3);
  end

  // store a byte only on an edge where both sides agree, offset order
  always @(posedge clock) begin
    if (cap_clear) begin
      cap_count <= 10'h000;
    end else if (dout_valid && dout_ready && cap_count < 10'h200) begin
      cap_mem[cap_count[8:0]] <= dout_data;
      cap_count <= cap_count + 10'h001;
    end
  end
endmodule

// ===== bench/testbench.sv
// self-checking bench for the monitoring log and status command block
`timescale 1ns/1ps
module testbench
  import smlg_pkg::*;
;
  typedef struct packed {
    logic [7:0] sub;
    logic [7:0] cnt;
    logic [7:0] adr;
    logic [2:0] res;
  } smlg_row_type;
  logic         clock, nrst, cmd_valid, busy, done, abort;
  smlg_cmd_type cmd;
  logic [7:0]   lba_mid, lba_high, din_data, dout_data, sum, coll_st, stest_st;
  logic         din_valid, din_ready, dout_valid, dout_ready, nv_enable, enable_state;
  logic         upd_valid, power_save, auto_tick, offline_start, offline_scan;
  logic         auto_offline, read_scan, cap_clear, last_scan;
  smlg_upd_type upd;
  logic [9:0]   cap_count;
  logic [7:0]   starts;
  int           errors, total_checks, k;
  // rows: subcommand, count, address, expected abort/auto/scan
  smlg_row_type rows [0:17] = '{
    {SC_DIS, 8'h00, 8'h00, 3'b100}, {SC_STAT, 8'h00, 8'h00, 3'b100},
    {SC_AUTO, AO_AUTO_ON, 8'h00, 3'b100}, {SC_EN, 8'h00, 8'h00, 3'b000},
    {SC_EN, 8'h00, 8'h00, 3'b000}, {SC_AUTO, AO_AUTO_ON, 8'h00, 3'b010},
    {SC_AUTO, AO_SCAN_ON, 8'h00, 3'b011}, {SC_AUTO, 8'h07, 8'h00, 3'b111},
    {SC_AUTO, AO_AUTO_OFF, 8'h00, 3'b001}, {SC_AUTO, AO_SCAN_OFF, 8'h00, 3'b000},
    {SC_AUTO, AO_SCAN_ON, 8'h00, 3'b001}, {SC_OFFIMM, 8'h00, 8'h01, 3'b101},
    {SC_WRLOG, 8'h02, LA_HOST0, 3'b101}, {SC_WRLOG, 8'h01, LA_ERR, 3'b101},
    {SC_WRLOG, 8'h01, LA_STEST, 3'b101}, {SC_RDLOG, 8'h02, LA_DIR, 3'b101},
    {SC_RDLOG, 8'h01, 8'h03, 3'b101}, {8'h77, 8'h00, 8'h00, 3'b101}};

  smlg_top dut_u (.clock(clock), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd),
    .busy(busy), .done(done), .abort(abort), .lba_mid(lba_mid), .lba_high(lba_high),
    .din_valid(din_valid), .din_data(din_data), .din_ready(din_ready),
    .dout_valid(dout_valid), .dout_data(dout_data), .dout_ready(dout_ready),
    .nv_enable(nv_enable), .enable_state(enable_state), .upd_valid(upd_valid),
    .upd(upd), .power_save(power_save), .auto_tick(auto_tick),
    .coll_status(coll_st), .stest_status(stest_st), .offline_start(offline_start),
    .offline_scan(offline_scan), .auto_offline(auto_offline), .read_scan(read_scan));
  smlg_host_model hm_u (.clock(clock), .dout_valid(dout_valid), .dout_data(dout_data),
    .dout_ready(dout_ready), .cap_clear(cap_clear), .cap_count(cap_count));

  // free-running 40 MHz clock
  initial clock = 1'b0;
  always #12.5 clock = ~clock;

  // count collection starts and keep the scan choice of the latest one
  always @(negedge clock) begin
    if (offline_start === 1'b1) begin
      starts <= starts + 8'h01;
      last_scan <= offline_scan;
    end
  end

  task automatic chk_v(input logic [15:0] g, input logic [15:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  task automatic chk_b(input logic g, input logic e, input string m);
    chk_v({15'h0000, g}, {15'h0000, e}, m);
  endtask

  // offer a command once busy is low, then wait for its completion pulse
  task automatic run_cmd(input logic [7:0] s, input logic [7:0] c, input logic [7:0] a);
    int n;
    // one edge between commands so cmd_valid never flips twice at one time
    @(negedge clock);
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    cmd_valid = 1'b1;
    cmd = '{s, c, a};
    @(negedge clock);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    chk_b(n < 3000, 1'b1, "completion pulse");
  endtask

  // valid stays high after a take; the caller lowers it after a burst
  task automatic push(input logic [7:0] v);
    int n;
    n = 0;
    din_valid = 1'b1;
    din_data = v;
    while (din_ready !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
  endtask

  task automatic read_sector(input logic [7:0] s, input logic [7:0] a);
    cap_clear = 1'b1;
    @(negedge clock);
    cap_clear = 1'b0;
    run_cmd(s, 8'h01, a);
    chk_v({6'h00, cap_count}, 16'h0200, "bytes read");
  endtask

  task automatic send_upd(input logic [4:0] i, input logic [7:0] v, input logic p);
    upd = '{i, v, 8'h20, p};
    upd_valid = 1'b1;
    @(negedge clock);
    upd_valid = 1'b0;
  endtask

  task automatic tick;
    auto_tick = 1'b1;
    @(negedge clock);
    auto_tick = 1'b0;
    repeat (3) @(negedge clock);
  endtask

  // the kept enable state goes round through the outside store
  task automatic cycle_power;
    nv_enable = enable_state;
    nrst = 1'b0;
    repeat (5) @(negedge clock);
    nrst = 1'b1;
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // a hang is cut short well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clock);
    errors++;
    conclude();
  end

  initial begin
    nrst = 1'b0;
    {cmd_valid, din_valid, upd_valid, power_save, auto_tick, nv_enable, cap_clear} = 7'h00;
    cmd = '0;
    upd = '0;
    din_data = 8'h00;
    coll_st = 8'h5a;
    stest_st = 8'h21;
    starts = 8'h00;
    last_scan = 1'b0;
    errors = 0;
    total_checks = 0;
    repeat (5) @(negedge clock);
    chk_b(busy, 1'b1, "busy in reset");
    nrst = 1'b1;
    send_upd(5'h03, 8'h10, 1'b1);
    for (k = 0; k < 18; k++) begin
      run_cmd(rows[k].sub, rows[k].cnt, rows[k].adr);
      chk_b(abort, rows[k].res[2], "abort");
      chk_b(auto_offline, rows[k].res[1], "auto setting");
      chk_b(read_scan, rows[k].res[0], "scan setting");
    end
    chk_b(enable_state, 1'b1, "enabled");
    run_cmd(SC_STAT, 8'h00, 8'h00);
    chk_v({lba_high, lba_mid}, {SIG_OK_HIGH, SIG_OK_MID}, "untracked sample");
    // scan on with automatic collection off
    run_cmd(SC_OFFIMM, 8'h00, OFF_COLLECT);
    tick();
    chk_v(starts, 8'h01, "host start only");
    chk_b(last_scan, 1'b1, "scan in host run");
    run_cmd(SC_AUTO, AO_SCAN_OFF, 8'h00);
    run_cmd(SC_AUTO, AO_AUTO_ON, 8'h00);
    tick();
    chk_v(starts, 8'h02, "automatic start");
    chk_b(last_scan, 1'b0, "no scan");
    // advisory crossing is harmless, prefailure crossing is not
    send_upd(5'h02, 8'h10, 1'b0);
    run_cmd(SC_STAT, 8'h00, 8'h00);
    chk_v({lba_high, lba_mid}, {SIG_OK_HIGH, SIG_OK_MID}, "advisory");
    send_upd(5'h03, 8'h10, 1'b1);
    run_cmd(SC_STAT, 8'h00, 8'h00);
    chk_v({lba_high, lba_mid}, {SIG_BAD_HIGH, SIG_BAD_MID}, "prefail");
    read_sector(SC_RDATTR, 8'h00);
    chk_v({hm_u.cap_mem[1], hm_u.cap_mem[0]}, REV_VAL, "revision");
    chk_v({hm_u.cap_mem[39], hm_u.cap_mem[38]}, 16'h0304, "entry 4 id");
    chk_v({hm_u.cap_mem[27], hm_u.cap_mem[41]}, 16'h0210, "entries");
    chk_v({hm_u.cap_mem[9'h16a], hm_u.cap_mem[9'h16f]}, {coll_st, OCAP_VAL}, "status");
    chk_v({hm_u.cap_mem[9'h16b], hm_u.cap_mem[9'h170]}, {stest_st, SCAP_VAL}, "test");
    chk_v({hm_u.cap_mem[9'h172], hm_u.cap_mem[9'h171]}, {ELOG_VAL, 8'h00}, "logging");
    chk_v(hm_u.cap_mem[9'h1fe], 16'h0000, "reserved zero");
    sum = 8'h00;
    for (k = 0; k < 512; k++) begin
      sum = sum + hm_u.cap_mem[k];
    end
    chk_v(sum, 16'h0000, "checksum");
    // fifo fills until it refuses, then the write drains it
    for (k = 0; k < 8; k++) begin
      push(8'(k) ^ 8'ha5);
    end
    chk_b(din_ready, 1'b0, "fifo full");
    fork
      run_cmd(SC_WRLOG, 8'h01, LA_HOST1);
      begin
        for (k = 8; k < 512; k++) begin
          push(8'(k) ^ 8'ha5);
        end
        din_valid = 1'b0;
      end
    join
    chk_b(abort, 1'b0, "write accepted");
    read_sector(SC_RDLOG, LA_HOST1);
    for (k = 0; k < 512; k++) begin
      chk_v(hm_u.cap_mem[k], 8'(k) ^ 8'ha5, "log byte");
    end
    // monitoring off stops tracking, power-mode saves still go through
    send_upd(5'h03, 8'h30, 1'b1);
    run_cmd(SC_DIS, 8'h00, 8'h00);
    chk_b(enable_state, 1'b0, "disabled");
    send_upd(5'h03, 8'h44, 1'b1);
    chk_v(dut_u.live_q[3], 16'h0030, "tracking stopped");
    power_save = 1'b1;
    @(negedge clock);
    power_save = 1'b0;
    chk_v(dut_u.saved_q[3], 16'h0030, "power-mode save");
    run_cmd(SC_RDATTR, 8'h00, 8'h00);
    chk_b(abort, 1'b1, "read refused");
    // the kept state comes back after each power cycle
    cycle_power();
    run_cmd(SC_STAT, 8'h00, 8'h00);
    chk_b(enable_state, 1'b0, "kept off");
    chk_b(abort, 1'b1, "still refused");
    run_cmd(SC_EN, 8'h00, 8'h00);
    cycle_power();
    run_cmd(SC_STAT, 8'h00, 8'h00);
    chk_b(enable_state, 1'b1, "kept state");
    chk_b(abort, 1'b0, "enabled after reset");
    conclude();
  end
endmodule
